// ---- logic/rpss_seq.sv ----
// Reset pin-state sequencer: holds, floats and forces pin groups during
// reset and releases them a fixed count of CPU clocks after reset rises.
// Assumes the core supplies pin values and directions synchronous to
// i_ref_clk, and the board resolves pin wires from the output enables.
//
// Overview of operation
// RQ1 - Keeper pins hold prior level during reset
// RQ2 - Keeper pins take core levels within limit
// RQ3 - Flag and interrupt pins driven high after release
// RQ4 - Float pins stay undriven until configured
// RQ5 - Float pins stop driving at once on reset
// RQ6 - Warm reset held low three clocks
// RQ7 - Power-up reset held after oscillator stable
// RQ8 - Power-up reset held after clock output valid
// RQ9 - Release timed by counting synchronized reset release
`timescale 1ns/1ns

// Data holding register with no reset, so it survives reset
module rpss_hold_reg #(
  parameter int W = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_load,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  always_ff @(posedge i_ref_clk) begin
    if (i_load) begin
      o_q <= i_d;
    end
  end

endmodule

module rpss_seq (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [rpss_pkg::KEEP_W-1:0] i_keeper_core,
  input wire logic [rpss_pkg::HIGH_W-1:0] i_high_core,
  input wire logic [rpss_pkg::FLOAT_W-1:0] i_float_core,
  input wire logic [rpss_pkg::FLOAT_W-1:0] i_float_dir,
  input wire logic [rpss_pkg::FLOAT_W-1:0] i_float_pins,
  output logic [rpss_pkg::KEEP_W-1:0] o_keeper_pins,
  output logic [rpss_pkg::HIGH_W-1:0] o_high_pins,
  output rpss_pkg::rpss_float_drv_t o_float_drv,
  output logic [rpss_pkg::FLOAT_W-1:0] o_float_in,
  output logic o_released
);

  // The released flag lands on edge 37 and is first sampled high on edge 38
  localparam int A_REL_DLY = rpss_pkg::REL_LIMIT_CYC - 1;

  rpss_pkg::rpss_state_t q;
  rpss_pkg::rpss_state_t next_q;
  logic keep_load;

  // The reset pin itself is the board's concern; only its release is timed
  // RQ6 RQ7 RQ8

  always_comb begin
    next_q = q;
    // Release is synchronized before it may start the count
    next_q.sync_a = 1'b1; // RQ9
    next_q.sync_b = q.sync_a; // RQ9
    case (q.phase)
      rpss_pkg::RPSS_HELD: begin
        if (q.sync_b) begin
          next_q.phase = rpss_pkg::RPSS_COUNT; // RQ9
          next_q.cnt = rpss_pkg::CNT_ZERO;
        end
      end
      rpss_pkg::RPSS_COUNT: begin
        if (q.cnt == rpss_pkg::CNT_LAST) begin
          next_q.phase = rpss_pkg::RPSS_RUN; // RQ9
          next_q.high = rpss_pkg::HIGH_POST; // RQ3
        end else begin
          next_q.cnt = q.cnt + rpss_pkg::CNT_ONE; // RQ9
        end
      end
      rpss_pkg::RPSS_RUN: begin
        next_q.high = i_high_core;
        // Undriven until the core sets a direction bit
        next_q.flt.oe = i_float_dir; // RQ4
        next_q.flt.out = i_float_core;
      end
      default: begin
        next_q = rpss_pkg::STATE_RST;
      end
    endcase
  end

  // Asynchronous reset drops every float enable immediately
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= rpss_pkg::STATE_RST; // RQ5
    end else begin
      q <= next_q;
    end
  end

  // Keeper capture stops the moment reset goes low
  assign keep_load = i_rst_b && (q.phase == rpss_pkg::RPSS_RUN); // RQ1 RQ2

  rpss_hold_reg #(
    .W(rpss_pkg::KEEP_W)
  ) u_keep (
    .i_ref_clk(i_ref_clk),
    .i_load(keep_load),
    .i_d(i_keeper_core),
    .o_q(o_keeper_pins)
  );

  assign o_high_pins = q.high;
  assign o_float_drv = q.flt;
  assign o_float_in = i_float_pins;
  assign o_released = (q.phase == rpss_pkg::RPSS_RUN);

  sequence s_rst_rise;
    $rose(i_rst_b);
  endsequence

  sequence s_release;
    $rose(o_released);
  endsequence

  // Two released edges in a row: the pin flops now follow the core
  sequence s_run_steady;
    o_released ##1 o_released;
  endsequence

  // Checked while reset is low, so no disable here
  a_keeper_hold_rst: assert property ( // RQ1
    @(posedge i_ref_clk) (!i_rst_b ##1 !i_rst_b) |->
      (o_keeper_pins === $past(o_keeper_pins))
  ) else $error("keeper pins changed during reset");

  a_float_off_rst: assert property ( // RQ5
    @(posedge i_ref_clk) !i_rst_b |-> (o_float_drv.oe == rpss_pkg::FLOAT_RST)
  ) else $error("float pins driven during reset");

  a_release_time_exact: assert property ( // RQ9
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    s_rst_rise |-> ##A_REL_DLY o_released
  ) else $error("release not at expected edge");

  a_release_not_early: assert property ( // RQ9
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    s_rst_rise |-> ##1 !o_released [*8]
  ) else $error("release came too early");

  a_keeper_post_rel: assert property ( // RQ2
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    s_release |=> (o_keeper_pins == $past(i_keeper_core))
  ) else $error("keeper pins not updated after release");

  a_high_forced_set: assert property ( // RQ3
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    s_release |-> (o_high_pins == rpss_pkg::HIGH_POST)
  ) else $error("high group not high at release");

  a_float_z_release: assert property ( // RQ4
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    s_release |-> (o_float_drv.oe == rpss_pkg::FLOAT_RST)
  ) else $error("float pins driven at release");

  a_float_dir_follow: assert property ( // RQ4
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (o_released && $past(o_released)) |-> (o_float_drv.oe == $past(i_float_dir))
  ) else $error("float enable does not follow direction");

  a_count_bound_max: assert property ( // RQ9
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    q.cnt <= rpss_pkg::CNT_LAST
  ) else $error("release counter overran");

  // Reset-time checks carry no disable, like the keeper hold check
  a_high_low_rst: assert property ( // RQ3
    @(posedge i_ref_clk) !i_rst_b |-> (o_high_pins == rpss_pkg::HIGH_RST)
  ) else $error("high group not low during reset");

  a_float_out_rst: assert property ( // RQ5
    @(posedge i_ref_clk) !i_rst_b |-> (o_float_drv.out == rpss_pkg::FLOAT_RST)
  ) else $error("float values not cleared during reset");

  a_release_clr_rst: assert property ( // RQ9
    @(posedge i_ref_clk) !i_rst_b |-> !o_released
  ) else $error("released flag set during reset");

  // Two synchronizer edges, then the count starts from zero
  a_count_start_sync: assert property ( // RQ9
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    s_rst_rise |-> ##3 (q.phase == rpss_pkg::RPSS_COUNT && q.cnt == rpss_pkg::CNT_ZERO)
  ) else $error("count did not start after synchronizer");

  a_count_step_one: assert property ( // RQ9
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (q.phase == rpss_pkg::RPSS_COUNT && $past(q.phase) == rpss_pkg::RPSS_COUNT) |->
      (q.cnt == $past(q.cnt) + rpss_pkg::CNT_ONE)
  ) else $error("release counter skipped a step");

  a_release_from_cnt: assert property ( // RQ9
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    s_release |-> ($past(q.cnt) == rpss_pkg::CNT_LAST)
  ) else $error("release before count completed");

  a_release_sticky: assert property ( // RQ9
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    o_released |=> o_released
  ) else $error("released flag dropped without reset");

  a_keeper_follow_run: assert property ( // RQ2
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    s_run_steady |-> (o_keeper_pins == $past(i_keeper_core))
  ) else $error("keeper pins do not follow core");

  a_high_follow_core: assert property ( // RQ3
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    s_run_steady |-> (o_high_pins == $past(i_high_core))
  ) else $error("high group does not follow core");

  a_float_out_follow: assert property ( // RQ4
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    s_run_steady |-> (o_float_drv.out == $past(i_float_core))
  ) else $error("float values do not follow core");

endmodule

// ---- pkg/rpss_pkg.sv ----
// Constants, types and state layout for the reset pin-state sequencer.
// Assumes one CPU clock at CLK_PERIOD_NS drives the whole block.
package rpss_pkg;

  // Pin group widths
  localparam int KEEP_W = 16;
  localparam int FLOAT_W = 16;
  localparam int HIGH_W = 2;
  localparam int HIGH_HOST_INTERRUPT_OUTPUT_BIT = 1;
  localparam int HIGH_FLAG_BIT = 0;

  // CPU clock period
  localparam int CLK_PERIOD_NS = 50;

  // Latest release after reset rises: 38 periods plus 15 ns
  localparam int REL_LIMIT_PERIODS = 38;
  localparam int REL_LIMIT_EXTRA_NS = 15;
  localparam int REL_LIMIT_CYC =
    (REL_LIMIT_PERIODS * CLK_PERIOD_NS + REL_LIMIT_EXTRA_NS) / CLK_PERIOD_NS;

  // Latest float release after reset falls: 1 period plus 15 ns
  localparam int FALL_LIMIT_PERIODS = 1;
  localparam int FALL_LIMIT_EXTRA_NS = 15;

  // Two synchronizer edges, one edge into counting, one edge for pin flops
  localparam int SYNC_STAGES = 2;
  localparam int RELEASE_WAIT = REL_LIMIT_CYC - SYNC_STAGES - 2;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RELEASE_WAIT - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

  // Post-reset level of the forced-high group
  localparam logic [HIGH_W-1:0] HIGH_POST = 2'h3;
  localparam logic [HIGH_W-1:0] HIGH_RST = 2'h0;
  localparam logic [FLOAT_W-1:0] FLOAT_RST = 16'h0000;

  typedef enum logic [2:0] {
    RPSS_HELD  = 3'b001,
    RPSS_COUNT = 3'b010,
    RPSS_RUN   = 3'b100
  } rpss_phase_t;

  typedef struct packed {
    logic [FLOAT_W-1:0] out;
    logic [FLOAT_W-1:0] oe;
  } rpss_float_drv_t;

  typedef struct packed {
    rpss_phase_t phase;
    logic [CNT_W-1:0] cnt;
    logic sync_a;
    logic sync_b;
    logic [HIGH_W-1:0] high;
    rpss_float_drv_t flt;
  } rpss_state_t;

  localparam rpss_state_t STATE_RST = '{
    phase: RPSS_HELD,
    cnt: CNT_ZERO,
    sync_a: 1'b0,
    sync_b: 1'b0,
    high: HIGH_RST,
    flt: '{out: FLOAT_RST, oe: FLOAT_RST}
  };

endpackage

// ---- bench/rpss_board.sv ----
// Board model: external reset source and float group pin wires.
// Assumes the bench asks for reset on i_req; undriven pins wander.
`timescale 1ns/1ns
module rpss_board (
  input wire logic i_ref_clk,
  input wire logic i_req,
  input wire rpss_pkg::rpss_float_drv_t i_drv,
  output logic o_rst_b,
  output logic [rpss_pkg::FLOAT_W-1:0] o_pins
);
  logic [1:0] held;
  logic [rpss_pkg::FLOAT_W-1:0] wander;
  initial begin
    held = 2'h0;
    wander = 16'hA5C3;
    // Reset falls after time zero so the design always sees the edge
    #1 o_rst_b = 1'b0;
  end
  always @(posedge i_ref_clk) begin
    wander <= ~wander;
    if (i_req) begin
      o_rst_b <= 1'b0;
      held <= 2'h0;
    end else if (held != 2'h3) begin
      held <= held + 2'h1;
    end else begin
      o_rst_b <= 1'b1;
    end
  end
  // Undriven bits show a pattern that flips every cycle
  assign o_pins = (i_drv.out & i_drv.oe) | (wander & ~i_drv.oe);
endmodule

// ---- bench/reset_pin_state_sequencer_test.sv ----
// Self-checking bench for the reset pin-state sequencer.
// Assumes a 20 MHz clock and the board model driving reset and pins.
`timescale 1ns/1ns
module reset_pin_state_sequencer_test;
  typedef struct packed {
    logic [15:0] k;
    logic [1:0] h;
    logic [15:0] f;
    logic [15:0] d;
  } rpss_row_t;
  rpss_row_t rows [4] = '{'{16'hFFFF, 2'h3, 16'hFFFF, 16'hFFFF},
    '{16'h0000, 2'h0, 16'h0000, 16'h0000}, '{16'h5A5A, 2'h1, 16'h3C3C, 16'h00FF},
    '{16'hA5A5, 2'h2, 16'hC3C3, 16'hF00F}};
  logic i_ref_clk, req, rst_b, rel;
  logic [15:0] kc, fc, fd, fi, kp, fp, last;
  logic [1:0] hc, hp;
  rpss_pkg::rpss_float_drv_t drv;
  int n_errors = 0;
  int tests_run = 0;
  rpss_board board (.i_ref_clk(i_ref_clk), .i_req(req), .i_drv(drv), .o_rst_b(rst_b),
    .o_pins(fp));
  rpss_seq uut (.i_ref_clk(i_ref_clk), .i_rst_b(rst_b), .i_keeper_core(kc),
    .i_high_core(hc), .i_float_core(fc), .i_float_dir(fd), .i_float_pins(fp),
    .o_keeper_pins(kp), .o_high_pins(hp), .o_float_drv(drv), .o_float_in(fi),
    .o_released(rel));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Release walk: counted from the first edge that sees reset high
  task automatic walk();
    @(posedge rst_b);
    repeat (36) @(posedge i_ref_clk);
    #1 chk("released early", 32'h0, {31'h0, rel});
    chk("high early", 32'h0, {30'h0, hp});
    @(posedge i_ref_clk);
    #1 chk("released", 32'h1, {31'h0, rel});
    chk("high forced", 32'h3, {30'h0, hp});
    chk("float undriven", 32'h0, drv);
    @(posedge i_ref_clk);
    #1 chk("keeper", {16'h0, kc}, {16'h0, kp});
    chk("float drive", {fc, fd}, drv);
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    #15000 n_errors++;
    end_of_test();
  end
  initial begin
    req = 1'b1;
    {kc, hc, fc, fd} = rows[2];
    hc = 2'h0;
    repeat (16) @(posedge i_ref_clk);
    req <= 1'b0;
    walk();
    foreach (rows[i]) begin
      @(posedge i_ref_clk);
      {kc, hc, fc, fd} <= rows[i];
      repeat (2) @(posedge i_ref_clk);
      #1 chk("keeper row", {16'h0, rows[i].k}, {16'h0, kp});
      chk("high row", {30'h0, rows[i].h}, {30'h0, hp});
      chk("float row", {rows[i].f, rows[i].d}, drv);
      chk("float in", {16'h0, fc & fd}, {16'h0, fi & fd});
    end
    last = kp;
    @(posedge i_ref_clk);
    req <= 1'b1;
    @(negedge rst_b);
    #1 chk("float off", 32'h0, drv);
    chk("high off", 32'h0, {30'h0, hp});
    chk("released off", 32'h0, {31'h0, rel});
    @(posedge i_ref_clk);
    kc <= 16'h0F0F;
    repeat (4) @(posedge i_ref_clk);
    #1 chk("keeper held", {16'h0, last}, {16'h0, kp});
    @(posedge i_ref_clk);
    req <= 1'b0;
    walk();
    end_of_test();
  end
endmodule
